// [icache_pkg.sv]
// Constants, field layout and encodings of the instruction cache control.
// Assumes the host core numbers register bits big-endian (bit 0 = MSB)
// and that all logic runs on one processor clock.
// Operation
// - icbi address is rB plus rA, or rB alone when rA is register zero.
// - icbi invalidates the matching line so later fetches miss to memory.
// - icbi to a load-inaccessible target may raise the data storage error.
// - icbi is treated as a supervisor-level instruction.
// - Cache is 4 Kbytes: 128 sets, two ways, four words per line.
// - Every line covers a memory block aligned on four words.
// - A miss issues a four-beat, one-word-per-beat burst at the fetch address.
// - First bus word is the requested one and is forwarded at once.
// - With no empty unlocked way, the victim is the least-recently-used unlocked way.
// - Any line can be locked to stay resident as instruction memory.
// - User-mode access to the three control registers traps, no effect.
// - Enable status bit 0 is read-only, 1 when enabled.
// - Command field bits 4 to 6 hold the eight command encodings.
// - Bits 10, 11, 12 are sticky error flags kept until cleared.
// - Address register write sets the address used by later commands.
// - Data port register returns data read from the tag array.
// - Hardware only sets error flags; reading them clears them.
// - Invalidate all clears unlocked lines and leaves locked lines.
// - Address bits 21-27 pick the set, bits 0-20 are the tag.
package icache_pkg;
   // Geometry
   localparam int ADDR_W   = 32;
   localparam int WORD_W   = 32;
   localparam int WAYS     = 2;
   localparam int SETS     = 128;
   localparam int SET_W    = 7;
   localparam int WIDX_W   = 2;
   localparam int TAG_W    = 21;
   // Address fields, counted from the LSB
   localparam int WORD_LSB = 2;
   localparam int SET_LSB  = 4;
   localparam int TAG_LSB  = 11;
   // Register numbers
   localparam logic [9:0] SPR_CTRL = 10'h230;
   localparam logic [9:0] SPR_ADDR = 10'h231;
   localparam logic [9:0] SPR_DATA = 10'h232;
   // Control register fields, big-endian bit n sits at 31-n
   localparam int EN_BIT   = 31;
   localparam int CMD_LSB  = 25;
   localparam int CMD_W    = 3;
   localparam int ERR1_BIT = 21;
   localparam int ERR2_BIT = 20;
   localparam int ERR3_BIT = 19;
   // Data port layout of a tag read
   localparam int TRD_VALID_BIT = 31;
   localparam int TRD_LOCK_BIT  = 30;
   localparam int TRD_LRU_BIT   = 29;
   // Burst beat counting
   localparam logic [1:0] BEAT_FIRST = 2'h0;
   localparam logic [1:0] BEAT_LAST  = 2'h3;
   localparam logic [1:0] BEAT_STEP  = 2'h1;

   typedef enum logic [2:0] {
      CMD_NONE     = 3'b000,
      CMD_ENABLE   = 3'b001,
      CMD_DISABLE  = 3'b010,
      CMD_LOADLOCK = 3'b011,
      CMD_UNLOCK   = 3'b100,
      CMD_UNLK_ALL = 3'b101,
      CMD_INV_ALL  = 3'b110,
      CMD_RSVD     = 3'b111
   } cmd_e;

   typedef enum logic [2:0] {
      OP_FETCH  = 3'b000,
      OP_ICBI   = 3'b001,
      OP_LOCK   = 3'b010,
      OP_UNLOCK = 3'b011,
      OP_TAGRD  = 3'b100
   } op_e;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_LOOK = 2'b01,
      ST_FILL = 2'b10
   } state_e;
endpackage

// [cache_mem_if.sv]
// Port bundle between the cache controller and one of its arrays.
// Assumes one writer and one reader, both on the system clock.
`timescale 1ns/10ps
`default_nettype none
interface cache_mem_if #(
   parameter int AW    = 7,
   parameter int LANES = 2,
   parameter int W     = 32
);
   logic [AW-1:0]      addr;
   logic [LANES-1:0]   we;
   logic [W-1:0]       wdata;
   logic [LANES*W-1:0] rdata;
   modport ctrl (output addr, we, wdata, input rdata);
   modport mem  (input addr, we, wdata, output rdata);
endinterface
`default_nettype wire

// [cache_ram.sv]
// Single-port array with one write enable per lane and registered read.
// Assumes parameters match those of the connected bundle.
`timescale 1ns/10ps
`default_nettype none
module cache_ram #(
   parameter int AW    = 7,
   parameter int LANES = 2,
   parameter int W     = 32
) (
   // Clock
   input wire logic clk_sys_in,
   // Array port
   cache_mem_if.mem port_if
);
   // Refuse shapes the array cannot hold
   if (AW < 1 || LANES < 1 || W < 1) begin : g_bad
      $error("cache_ram: bad shape");
   end

   // One storage column per lane
   for (genvar l = 0; l < LANES; l++) begin : g_lane
      logic [W-1:0] ram [2**AW];
      logic [W-1:0] rd_q;
      always_ff @(posedge clk_sys_in) begin
         if (port_if.we[l]) begin
            ram[port_if.addr] <= port_if.wdata;
         end
         rd_q <= ram[port_if.addr]; // Old data on same-cycle write
      end
      assign port_if.rdata[l*W +: W] = rd_q;
   end
endmodule
`default_nettype wire

// [icache_ctrl.sv]
// Two-way instruction cache controller with command registers.
// Assumes fetch request held until answered, and bus beats come
// critical word first with wrap, one per rvalid pulse.
`timescale 1ns/10ps
`default_nettype none
module icache_ctrl
   import icache_pkg::*;
(
   // Clock and reset
   input  wire logic              clk_sys_in,
   input  wire logic              rstn_in,
   // Special register port
   input  wire logic              spr_rd_in,
   input  wire logic              spr_wr_in,
   input  wire logic [9:0]        spr_num_in,
   input  wire logic [WORD_W-1:0] spr_wdata_in,
   input  wire logic              user_mode_in,
   output logic                   spr_ack_out,
   output logic [WORD_W-1:0]      spr_rdata_out,
   output logic                   prog_int_out,
   output logic                   cache_busy_out,
   // Block invalidate instruction
   input  wire logic              icbi_in,
   input  wire logic [ADDR_W-1:0] icbi_ra_in,
   input  wire logic [ADDR_W-1:0] icbi_rb_in,
   input  wire logic              icbi_ra_zero_in,
   input  wire logic              icbi_load_ok_in,
   output logic                   icbi_done_out,
   output logic                   dstor_err_out,
   // Instruction unit
   input  wire logic              fetch_req_in,
   input  wire logic [ADDR_W-1:0] fetch_addr_in,
   output logic                   fetch_valid_out,
   output logic [WORD_W-1:0]      fetch_data_out,
   output logic                   mcheck_out,
   // Instruction bus
   output logic                   ibus_req_out,
   output logic [ADDR_W-1:0]      ibus_addr_out,
   input  wire logic              ibus_rvalid_in,
   input  wire logic [WORD_W-1:0] ibus_rdata_in,
   input  wire logic              ibus_err_in
);
   // Package geometry must agree with itself
   if (SETS != (1 << SET_W) || TAG_W + SET_W + WIDX_W + 2 != ADDR_W)
   begin : g_bad
      $error("icache_ctrl: inconsistent geometry");
   end
   function automatic logic [SET_W-1:0] set_of(logic [ADDR_W-1:0] a);
      return a[SET_LSB +: SET_W];
   endfunction
   function automatic logic [TAG_W-1:0] tag_of(logic [ADDR_W-1:0] a);
      return a[TAG_LSB +: TAG_W];
   endfunction
   function automatic logic [WIDX_W-1:0] word_of(logic [ADDR_W-1:0] a);
      return a[WORD_LSB +: WIDX_W];
   endfunction
   state_e              state_q;
   op_e                 op_q, cmd_op_q, pick;
   logic                go, en_q, icbi_pend_q, trd_pend_q;
   logic [ADDR_W-1:0]   sel_addr, lk_addr_q, cmd_addr_q, icbi_addr_q;
   logic [WORD_W-1:0]   trd_data_q;
   logic                err1_q, err2_q, err3_q;
   logic [WAYS-1:0]     valid_q [SETS];
   logic [WAYS-1:0]     lock_q  [SETS];
   logic [SETS-1:0]     lru_q;
   logic [1:0]          beat_q;
   logic                fill_way_q, fill_en_q, fill_bad_q;
   // Tag and data arrays, both ways side by side
   cache_mem_if #(.AW(SET_W), .LANES(WAYS), .W(TAG_W)) tag_if ();
   cache_mem_if #(.AW(SET_W + WIDX_W), .LANES(WAYS), .W(WORD_W)) dat_if ();
   cache_ram #(.AW(SET_W), .LANES(WAYS), .W(TAG_W)) u_tag (
      .clk_sys_in (clk_sys_in),
      .port_if    (tag_if)
   );
   cache_ram #(.AW(SET_W + WIDX_W), .LANES(WAYS), .W(WORD_W)) u_dat (
      .clk_sys_in (clk_sys_in),
      .port_if    (dat_if)
   );
   // Pick the next job: icbi, then command, then tag read, then fetch
   always_comb begin
      pick     = OP_FETCH;
      sel_addr = fetch_addr_in;
      go       = fetch_req_in && !fetch_valid_out && !mcheck_out;
      if (icbi_pend_q) begin
         pick     = OP_ICBI;
         sel_addr = icbi_addr_q;
         go       = 1'b1;
      end else if (cache_busy_out) begin
         pick     = cmd_op_q;
         sel_addr = cmd_addr_q;
         go       = 1'b1;
      end else if (trd_pend_q) begin
         pick     = OP_TAGRD;
         sel_addr = cmd_addr_q;
         go       = 1'b1;
      end
   end
   // Lookup result of the set read in the previous cycle
   logic [SET_W-1:0]  lk_set, f_set;
   logic [WAYS-1:0]   hit, vv, lk;
   logic              hway, vic, vic_ok;
   always_comb begin
      lk_set = set_of(lk_addr_q);
      f_set  = lk_set;
      vv     = valid_q[lk_set];
      lk     = lock_q[lk_set];
      for (int w = 0; w < WAYS; w++) begin
         hit[w] = vv[w] &&
            (tag_if.rdata[w*TAG_W +: TAG_W] == tag_of(lk_addr_q));
      end
      hway   = hit[1];
      vic_ok = 1'b1;
      // Empty unlocked way first, then LRU, never a locked way
      if (!vv[0] && !lk[0]) begin
         vic = 1'b0;
      end else if (!vv[1] && !lk[1]) begin
         vic = 1'b1;
      end else if (!lk[lru_q[lk_set]]) begin
         vic = lru_q[lk_set];
      end else begin
         vic    = ~lru_q[lk_set];
         vic_ok = !lk[vic];
      end
   end
   // Events derived from state
   wire logic look       = state_q == ST_LOOK;
   wire logic fetch_hit  = look && op_q == OP_FETCH && en_q && |hit;
   wire logic lock_now   = look && op_q == OP_LOCK && en_q && |hit;
   wire logic start_fill = look && ((op_q == OP_FETCH && !(en_q && |hit)) ||
                     (op_q == OP_LOCK && en_q && !(|hit) && vic_ok));
   wire logic fill_en    = en_q && vic_ok;
   wire logic beat       = state_q == ST_FILL && ibus_rvalid_in;
   wire logic first      = beat && beat_q == BEAT_FIRST;
   wire logic last       = beat && beat_q == BEAT_LAST;
   wire logic fill_good  = last && fill_en_q && !fill_bad_q && !ibus_err_in;
   wire logic spr_hit    = spr_num_in == SPR_CTRL || spr_num_in == SPR_ADDR ||
                      spr_num_in == SPR_DATA;
   wire logic ctrl_wr    = spr_wr_in && !user_mode_in && spr_num_in == SPR_CTRL;
   wire logic addr_wr    = spr_wr_in && !user_mode_in && spr_num_in == SPR_ADDR;
   wire logic cmd_done   = (look && (op_q == OP_LOCK || op_q == OP_UNLOCK) &&
                      !start_fill) || (last && op_q == OP_LOCK);
   cmd_e      wr_cmd;
   assign wr_cmd = cmd_e'(spr_wdata_in[CMD_LSB +: CMD_W]);
   // Array addressing: lookup from the picked job, fill from the burst
   always_comb begin
      tag_if.wdata = tag_of(lk_addr_q);
      dat_if.wdata = ibus_rdata_in;
      tag_if.we    = '0;
      dat_if.we    = '0;
      if (state_q == ST_FILL) begin
         tag_if.addr = f_set;
         dat_if.addr = {f_set, WIDX_W'(word_of(lk_addr_q) + beat_q)};
         if (beat && fill_en_q) begin
            dat_if.we = fill_way_q ? 2'h2 : 2'h1;
            tag_if.we = (first && fill_way_q) ? 2'h2 :
                        first ? 2'h1 : 2'h0;
         end
      end else begin
         tag_if.addr = set_of(sel_addr);
         dat_if.addr = {set_of(sel_addr), word_of(sel_addr)};
      end
   end
   // Sequencer: idle, lookup, burst fill
   always_ff @(posedge clk_sys_in or negedge rstn_in) begin
      if (!rstn_in) begin
         state_q    <= ST_IDLE;
         op_q       <= OP_FETCH;
         lk_addr_q  <= '0;
         beat_q     <= BEAT_FIRST;
         {fill_way_q, fill_en_q, fill_bad_q} <= '0;
      end else begin
         unique case (state_q)
            ST_IDLE: begin
               if (go) begin
                  state_q   <= ST_LOOK;
                  op_q      <= pick;
                  lk_addr_q <= sel_addr;
               end
            end
            ST_LOOK: begin
               if (start_fill) begin
                  state_q    <= ST_FILL;
                  beat_q     <= BEAT_FIRST;
                  fill_way_q <= vic;
                  fill_en_q  <= fill_en;
                  fill_bad_q <= 1'b0;
               end else begin
                  state_q <= ST_IDLE;
               end
            end
            ST_FILL: begin
               if (beat) begin
                  beat_q     <= beat_q + BEAT_STEP;
                  fill_bad_q <= fill_bad_q | ibus_err_in;
                  if (last) begin
                     state_q <= ST_IDLE;
                  end
               end
            end
            default: state_q <= ST_IDLE;
         endcase
      end
   end
   // Valid, lock and replacement state of every line
   always_ff @(posedge clk_sys_in or negedge rstn_in) begin
      if (!rstn_in) begin
         for (int s = 0; s < SETS; s++) begin
            valid_q[s] <= '0;
            lock_q[s]  <= '0;
         end
         lru_q <= '0;
      end else begin
         if (ctrl_wr && !cache_busy_out && wr_cmd == CMD_INV_ALL) begin
            for (int s = 0; s < SETS; s++) begin
               valid_q[s] <= valid_q[s] & lock_q[s];
               lru_q[s]   <= lock_q[s][0] & ~lock_q[s][1];
            end
         end
         if (ctrl_wr && !cache_busy_out && wr_cmd == CMD_UNLK_ALL) begin
            for (int s = 0; s < SETS; s++) begin
               lock_q[s] <= '0;
            end
         end
         if (fetch_hit) begin
            lru_q[lk_set] <= ~hway;
         end
         if (start_fill && fill_en) begin
            valid_q[lk_set][vic] <= 1'b0;
         end
         if (look && op_q == OP_ICBI) begin
            valid_q[lk_set] <= vv & ~hit;
         end
         if (lock_now) begin
            lock_q[lk_set] <= lk | hit;
         end
         if (look && op_q == OP_UNLOCK) begin
            lock_q[lk_set] <= lk & ~hit;
         end
         if (fill_good) begin
            valid_q[f_set][fill_way_q] <= 1'b1;
            lru_q[f_set]               <= ~fill_way_q;
            if (op_q == OP_LOCK) begin
               lock_q[f_set][fill_way_q] <= 1'b1;
            end
         end
      end
   end
   // Instruction unit answers and bus request
   always_ff @(posedge clk_sys_in or negedge rstn_in) begin
      if (!rstn_in) begin
         {fetch_valid_out, mcheck_out, ibus_req_out} <= '0;
         {fetch_data_out, ibus_addr_out} <= '0;
      end else begin
         fetch_valid_out <= fetch_hit ||
            (first && op_q == OP_FETCH && !ibus_err_in);
         mcheck_out      <= first && op_q == OP_FETCH && ibus_err_in;
         if (fetch_hit) begin
            fetch_data_out <= dat_if.rdata[hway*WORD_W +: WORD_W];
         end else if (first) begin
            fetch_data_out <= ibus_rdata_in;
         end
         if (start_fill) begin
            ibus_req_out  <= 1'b1;
            ibus_addr_out <= lk_addr_q;
         end else if (last) begin
            ibus_req_out <= 1'b0;
         end
      end
   end
   // Block invalidate intake
   always_ff @(posedge clk_sys_in or negedge rstn_in) begin
      if (!rstn_in) begin
         {icbi_pend_q, icbi_done_out, dstor_err_out} <= '0;
         icbi_addr_q   <= '0;
      end else begin
         icbi_done_out <= look && op_q == OP_ICBI;
         dstor_err_out <= 1'b0;
         if (icbi_in && !icbi_pend_q) begin
            if (user_mode_in) begin
               icbi_done_out <= 1'b1;
            end else if (!icbi_load_ok_in) begin
               dstor_err_out <= 1'b1;
               icbi_done_out <= 1'b1;
            end else begin
               icbi_pend_q <= 1'b1;
               icbi_addr_q <= (icbi_ra_zero_in ? '0 : icbi_ra_in) +
                              icbi_rb_in;
            end
         end else if (look && op_q == OP_ICBI) begin
            icbi_pend_q <= 1'b0;
         end
      end
   end
   // Register read mux
   logic [WORD_W-1:0] rd_mux;
   always_comb begin
      rd_mux = '0;
      if (spr_num_in == SPR_CTRL) begin
         rd_mux[EN_BIT]   = en_q;
         rd_mux[ERR1_BIT] = err1_q;
         rd_mux[ERR2_BIT] = err2_q;
         rd_mux[ERR3_BIT] = err3_q;
      end else if (spr_num_in == SPR_ADDR) begin
         rd_mux = cmd_addr_q;
      end else if (spr_num_in == SPR_DATA) begin
         rd_mux = trd_data_q;
      end
   end
   // Control registers, commands and error flags
   wire logic rd_clr = spr_rd_in && !user_mode_in && spr_num_in == SPR_CTRL;
   always_ff @(posedge clk_sys_in or negedge rstn_in) begin
      if (!rstn_in) begin
         {en_q, err1_q, err2_q, err3_q} <= '0;
         cmd_addr_q     <= '0;
         cmd_op_q       <= OP_LOCK;
         {cache_busy_out, trd_pend_q, spr_ack_out, prog_int_out} <= '0;
         {trd_data_q, spr_rdata_out} <= '0;
      end else begin
         spr_ack_out   <= (spr_rd_in || spr_wr_in) && spr_hit;
         spr_rdata_out <= spr_rd_in ? rd_mux : '0;
         prog_int_out  <= ((spr_rd_in || spr_wr_in) && spr_hit &&
                          user_mode_in) ||
                          (icbi_in && !icbi_pend_q && user_mode_in);
         // Set wins over the clear by read
         err1_q <= (look && op_q == OP_LOCK && en_q && !(|hit) &&
                    !vic_ok) || (err1_q && !rd_clr);
         err2_q <= (beat && op_q == OP_LOCK && ibus_err_in) ||
                   (err2_q && !rd_clr);
         err3_q <= (look && op_q == OP_LOCK && !en_q) ||
                   (err3_q && !rd_clr);
         if (cmd_done) begin
            cache_busy_out <= 1'b0;
         end
         if (look && op_q == OP_TAGRD) begin
            trd_pend_q                          <= 1'b0;
            trd_data_q                          <= '0;
            trd_data_q[TRD_VALID_BIT]           <= vv[lk_addr_q[0]];
            trd_data_q[TRD_LOCK_BIT]            <= lk[lk_addr_q[0]];
            trd_data_q[TRD_LRU_BIT]             <= lru_q[lk_set];
            trd_data_q[TAG_W-1:0]               <=
               tag_if.rdata[lk_addr_q[0]*TAG_W +: TAG_W];
         end
         if (addr_wr) begin
            cmd_addr_q <= spr_wdata_in;
            trd_pend_q <= 1'b1;
         end
         // Writes to bit 0 are dropped; only commands move it
         if (ctrl_wr && !cache_busy_out) begin
            unique case (wr_cmd)
               CMD_ENABLE:  en_q <= 1'b1;
               CMD_DISABLE: en_q <= 1'b0;
               CMD_LOADLOCK: begin
                  cache_busy_out <= 1'b1;
                  cmd_op_q       <= OP_LOCK;
               end
               CMD_UNLOCK: begin
                  cache_busy_out <= 1'b1;
                  cmd_op_q       <= OP_UNLOCK;
               end
               CMD_NONE, CMD_RSVD, CMD_UNLK_ALL, CMD_INV_ALL: ;
            endcase
         end
      end
   end
endmodule
`default_nettype wire

// [icache_props.sv]
// Checker on the ports of the instruction cache controller.
// Bound from the testbench; one clock, reset active low.
`timescale 1ns/10ps
`default_nettype none
module icache_props
   import icache_pkg::*;
(
   input wire logic        clk_sys_in, rstn_in, spr_rd_in, spr_wr_in,
   input wire logic [9:0]  spr_num_in,
   input wire logic        user_mode_in, spr_ack_out, prog_int_out,
   input wire logic        icbi_in, icbi_load_ok_in, icbi_done_out,
   input wire logic        dstor_err_out, fetch_req_in, fetch_valid_out,
   input wire logic        mcheck_out, ibus_req_out, ibus_rvalid_in,
   input wire logic        ibus_err_in,
   input wire logic [31:0] fetch_addr_in, fetch_data_out,
   input wire logic [31:0] ibus_addr_out, ibus_rdata_in
);
   default clocking @(posedge clk_sys_in); endclocking
   default disable iff (!rstn_in);
   logic [1:0] beat_q;
   logic       acc;
   logic       b0;
   // Beat number within the running burst
   always_ff @(posedge clk_sys_in or negedge rstn_in)
      if (!rstn_in) beat_q <= 2'h0;
      else if (ibus_req_out && ibus_rvalid_in) beat_q <= beat_q + 2'h1;
   // Register access and first beat of a fetch burst
   assign acc = (spr_rd_in || spr_wr_in)
      && spr_num_in inside {SPR_CTRL, SPR_ADDR, SPR_DATA};
   assign b0 = ibus_req_out && ibus_rvalid_in && beat_q == 2'h0
      && fetch_req_in;
   property p_ack;
      acc |=> spr_ack_out && prog_int_out == $past(user_mode_in);
   endproperty
   property p_dstor;
      icbi_in && !user_mode_in && !icbi_load_ok_in |=> icbi_done_out
         && dstor_err_out;
   endproperty
   property p_utrap;
      icbi_in && user_mode_in |=> icbi_done_out && prog_int_out;
   endproperty
   property p_baddr;
      $rose(ibus_req_out) && fetch_req_in |-> ibus_addr_out == fetch_addr_in;
   endproperty
   property p_bend;
      ibus_req_out && ibus_rvalid_in && beat_q == 2'h3 |=> !ibus_req_out;
   endproperty
   property p_bhold;
      ibus_req_out && $past(ibus_req_out) |-> $stable(ibus_addr_out);
   endproperty
   property p_fwd;
      b0 && !ibus_err_in |=> fetch_valid_out
         && fetch_data_out == $past(ibus_rdata_in);
   endproperty
   property p_mchk;
      b0 && ibus_err_in |=> mcheck_out && !fetch_valid_out;
   endproperty
   a_ack: assert property (p_ack) else $error("bad ack");
   a_dstor: assert property (p_dstor) else $error("no dstor");
   a_utrap: assert property (p_utrap) else $error("no trap");
   a_baddr: assert property (p_baddr) else $error("bad addr");
   a_bend: assert property (p_bend) else $error("bad beats");
   a_bhold: assert property (p_bhold) else $error("addr moved");
   a_fwd: assert property (p_fwd) else $error("no forward");
   a_mchk: assert property (p_mchk) else $error("no mcheck");
   c_trap: cover property (spr_ack_out && prog_int_out);
   c_dstor: cover property (dstor_err_out);
   c_mchk: cover property (mcheck_out);
endmodule
`default_nettype wire

// [ibus_mem_model.sv]
// Instruction bus memory answering each burst with four wrapping beats.
// Word data is the inverse of its word address; one beat may err.
`timescale 1ns/10ps
`default_nettype none
module ibus_mem_model (
   input  wire logic        clk_sys_in, rstn_in, req_in,
   input  wire logic [31:0] addr_in,
   input  wire logic [1:0]  slow_in,
   input  wire logic [2:0]  err_beat_in,
   output var  logic        rvalid_out, err_out,
   output var  logic [31:0] rdata_out
);
   logic [31:0] a;
   // Burst responder, critical word first
   initial begin
      {rvalid_out, err_out, rdata_out} = 34'h0;
      forever begin
         @(posedge clk_sys_in) #1;
         if (rstn_in && req_in) begin
            a = addr_in;
            repeat (slow_in) @(posedge clk_sys_in);
            #1 rvalid_out = 1;
            for (int k = 0; k < 4; k++) begin
               rdata_out = ~{a[31:4], a[3:2] + k[1:0], 2'h0};
               err_out = k == err_beat_in;
               @(posedge clk_sys_in) #1;
            end
            {rvalid_out, err_out} = 2'h0;
            rdata_out = ~rdata_out; // No stale word once released
         end
      end
   end
endmodule
`default_nettype wire

// [instruction_cache_control_test.sv]
// Self-checking bench for the instruction cache controller.
// Drives register, icbi and fetch ports; the bus model answers bursts.
`timescale 1ns/10ps
`default_nettype none
module instruction_cache_control_test;
   import icache_pkg::*;
   localparam logic [31:0] A = 32'h1230, B = 32'h1a30, C = 32'h2230;
   logic clk_sys_in = 0, rstn_in = 0, spr_rd_in = 0, spr_wr_in = 0;
   logic user_mode_in = 0, icbi_in = 0, icbi_ra_zero_in = 0, req_p = 0;
   logic icbi_load_ok_in = 1, fetch_req_in = 0;
   logic [9:0] spr_num_in = 0;
   logic [1:0] slow = 0;
   logic [2:0] err_beat = 3'h4;
   logic [31:0] spr_wdata_in = 0, icbi_ra_in = 0, icbi_rb_in = 0;
   logic [31:0] fetch_addr_in = 0, rd, t;
   logic spr_ack_out, prog_int_out, cache_busy_out, icbi_done_out;
   logic dstor_err_out, fetch_valid_out, mcheck_out, ibus_req_out;
   logic ibus_rvalid_in, ibus_err_in;
   logic [31:0] spr_rdata_out, fetch_data_out, ibus_addr_out, ibus_rdata_in;
   int fails = 0, checked = 0, bursts = 0;
   always #25 clk_sys_in = ~clk_sys_in;
   icache_ctrl u_icache_ctrl (.*);
   ibus_mem_model u_ibus_mem_model (.clk_sys_in, .rstn_in,
      .req_in(ibus_req_out), .addr_in(ibus_addr_out), .slow_in(slow),
      .err_beat_in(err_beat), .rvalid_out(ibus_rvalid_in),
      .err_out(ibus_err_in), .rdata_out(ibus_rdata_in));
   // Count bursts started on the bus
   always @(negedge clk_sys_in) begin
      if (ibus_req_out && !req_p) bursts++;
      req_p <= ibus_req_out;
   end
   task automatic chk(string n, logic [31:0] e, g);
      checked++;
      if (g !== e) begin
         fails++;
         $display("[ERR] %s exp %h got %h", n, e, g);
      end
   endtask
   task automatic spr(logic w, logic [9:0] n, logic [31:0] d, logic u);
      @(posedge clk_sys_in) #1;
      {spr_wr_in, spr_rd_in, spr_num_in, spr_wdata_in, user_mode_in} =
         {w, !w, n, d, u};
      @(posedge clk_sys_in) #1;
      {spr_wr_in, spr_rd_in, user_mode_in} = 3'h0;
      rd = spr_rdata_out;
      chk("ack", n != 10'h233, spr_ack_out);
      chk("trap", u, prog_int_out);
   endtask
   task automatic rdchk(logic [31:0] e);
      spr(0, SPR_CTRL, 0, 0);
      chk("ctrl", e, rd);
   endtask
   task automatic cmd(cmd_e c);
      spr(1, SPR_CTRL, {4'h0, c, 25'h0}, 0);
      repeat (40) begin
         @(posedge clk_sys_in) #1;
         if (cache_busy_out === 1'b0) break;
      end
   endtask
   task automatic fetch(logic [31:0] a, logic hit, logic e = 0);
      int n;
      n = bursts;
      @(posedge clk_sys_in) #1;
      {fetch_req_in, fetch_addr_in} = {1'b1, a};
      repeat (40) begin
         @(posedge clk_sys_in) #1;
         if (fetch_valid_out === 1'b1 || mcheck_out === 1'b1) break;
      end
      fetch_req_in = 0;
      chk("mcheck", e, mcheck_out);
      if (!e) chk("data", ~{a[31:2], 2'h0}, fetch_data_out);
      chk("hit", hit, bursts == n);
   endtask
   task automatic icbi(logic [31:0] ra, rb, logic z, ok, u);
      @(posedge clk_sys_in) #1;
      {icbi_in, icbi_ra_in, icbi_rb_in} = {1'b1, ra, rb};
      {icbi_ra_zero_in, icbi_load_ok_in, user_mode_in} = {z, ok, u};
      @(posedge clk_sys_in) #1;
      icbi_in = 0;
      repeat (20) begin
         if (icbi_done_out === 1'b1) break;
         @(posedge clk_sys_in) #1;
      end
      user_mode_in = 0;
      chk("dstor", !ok && !u, dstor_err_out);
      chk("trap", u, prog_int_out);
   endtask
   task automatic tagrd(logic w);
      spr(1, SPR_ADDR, A | w, 0);
      repeat (4) @(posedge clk_sys_in);
      spr(0, SPR_DATA, 0, 0);
   endtask
   function automatic logic m(logic [31:0] x);
      return x[31:30] == 2'b11 && x[20:0] == A[31:11];
   endfunction
   task end_of_test;
      $display("checked %0d fails %0d", checked, fails);
      if (fails == 0 && checked > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   // Watchdog
   initial begin
      #2_000_000;
      fails++;
      end_of_test();
   end
   // Test sequence
   initial begin
      repeat (20) @(posedge clk_sys_in);
      #1 rstn_in = 1;
      rdchk(0);
      spr(0, 10'h233, 0, 0);
      spr(1, SPR_CTRL, 32'h0200_0000, 1);
      spr(1, SPR_CTRL, 32'h8e00_0000, 0);
      rdchk(0);
      fetch(A, 0);
      fetch(A, 0);
      cmd(CMD_ENABLE);
      rdchk(32'h8000_0000);
      fetch(A, 0);
      fetch(A + 12, 1);
      fetch(B, 0);
      fetch(A, 1);
      fetch(C, 0);
      fetch(A, 1);
      fetch(B, 0);
      icbi(32'hdead_0000, A, 1, 1, 0);
      fetch(A, 0);
      icbi(A - 32'h100, 32'h100, 0, 1, 0);
      fetch(A, 0);
      icbi(0, A, 1, 1, 1);
      icbi(0, A, 1, 0, 0);
      fetch(A, 1);
      slow = 2'h2;
      spr(1, SPR_ADDR, A, 0);
      cmd(CMD_LOADLOCK);
      tagrd(0);
      t = rd;
      tagrd(1);
      chk("tag", 1, m(t) ^ m(rd));
      cmd(CMD_INV_ALL);
      fetch(A, 1);
      spr(1, SPR_ADDR, B, 0);
      cmd(CMD_LOADLOCK);
      spr(1, SPR_ADDR, C, 0);
      cmd(CMD_LOADLOCK);
      spr(0, SPR_CTRL, 0, 1);
      rdchk(32'h8020_0000);
      rdchk(32'h8000_0000);
      spr(1, SPR_ADDR, B, 0);
      cmd(CMD_UNLOCK);
      cmd(CMD_INV_ALL);
      fetch(B, 0);
      cmd(CMD_UNLK_ALL);
      cmd(CMD_INV_ALL);
      fetch(A, 0);
      err_beat = 3'h1;
      cmd(CMD_LOADLOCK);
      rdchk(32'h8010_0000);
      fetch(C, 0);
      fetch(C, 0);
      err_beat = 3'h0;
      fetch(B, 0, 1);
      err_beat = 3'h4;
      cmd(CMD_DISABLE);
      cmd(CMD_LOADLOCK);
      rdchk(32'h0008_0000);
      end_of_test();
   end
endmodule
bind icache_ctrl icache_props u_icache_props (.*);
`default_nettype wire
